// ### pkg/mac_regs_pkg.sv
// Register map, reset values and filter constants for the MAC pointer/filter/tally block
package mac_regs_pkg;
  typedef logic [7:0] byte_type;
  typedef logic [15:0] addr16_type;
  typedef logic [7:0] paddr_type;
  typedef logic [31:0] word_type;
  typedef logic [4:0] reg_idx_type;
  // Register index; byte address is index times four
  localparam reg_idx_type TX_LENGTH_LOW = 5'h00;
  localparam reg_idx_type TX_LENGTH_HIGH = 5'h01;
  localparam reg_idx_type RING_FIRST_PAGE = 5'h02;
  localparam reg_idx_type RING_LAST_PAGE = 5'h03;
  localparam reg_idx_type RING_GUARD_PAGE = 5'h04;
  localparam reg_idx_type RX_WRITE_PAGE = 5'h05;
  localparam reg_idx_type LOCAL_DMA_ADDR_LOW = 5'h06;
  localparam reg_idx_type LOCAL_DMA_ADDR_HIGH = 5'h07;
  localparam reg_idx_type HOST_XFER_START_LOW = 5'h08;
  localparam reg_idx_type HOST_XFER_START_HIGH = 5'h09;
  localparam reg_idx_type HOST_XFER_COUNT_LOW = 5'h0a;
  localparam reg_idx_type HOST_XFER_COUNT_HIGH = 5'h0b;
  localparam reg_idx_type HOST_XFER_ADDR_LOW = 5'h0c;
  localparam reg_idx_type HOST_XFER_ADDR_HIGH = 5'h0d;
  localparam reg_idx_type STATION_ADDR_BYTE0 = 5'h0e;
  localparam reg_idx_type HASH_FILTER_BYTE0 = 5'h14;
  localparam reg_idx_type ALIGNMENT_ERROR_TALLY = 5'h1c;
  localparam reg_idx_type CRC_ERROR_TALLY = 5'h1d;
  localparam reg_idx_type LOST_FRAME_TALLY = 5'h1e;
  localparam reg_idx_type LAST_REG = 5'h1e;
  localparam int NUM_REGS = 31;
  localparam int STATION_BYTES = 6;
  localparam int HASH_BYTES = 8;
  localparam byte_type REG_RESET = 8'h00;
  localparam byte_type TALLY_MAX = 8'hc0;
  localparam byte_type PAGE_OFFSET_ZERO = 8'h00;
  localparam int DA_BITS = 48;
  localparam logic [5:0] DA_LAST_BIT = 6'h2f;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam int HASH_MSB = 31;
  localparam int HASH_LSB = 26;
endpackage : mac_regs_pkg

// ### pkg/addr_filter_if.sv
// Carrier between the register block and the destination address filter
`timescale 1ns/1ns
interface addr_filter_if;
  logic bit_valid;
  logic bit_data;
  logic frame_start;
  logic group_enable;
  logic [47:0] station;
  logic [63:0] hash_bits;
  logic accept;
  logic is_group;
  logic done;
  modport regs (output bit_valid, bit_data, frame_start, group_enable, station, hash_bits,
                input accept, is_group, done);
  modport filter (input bit_valid, bit_data, frame_start, group_enable, station, hash_bits,
                  output accept, is_group, done);
endinterface : addr_filter_if

// ### logic/addr_filter.sv
// Serial destination address filter: station compare and CRC hash lookup
`timescale 1ns/1ns
module addr_filter
  import mac_regs_pkg::*;
(
  input wire logic i_clk,       // Bus clock
  input wire logic i_nrst,      // Async reset, active low
  addr_filter_if.filter flt     // Bits in, verdict out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DONE = 3'b100
  } filt_state_type;

  filt_state_type state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [47:0] da_q, da_d;
  logic [31:0] crc_q, crc_d;
  logic accept_q, accept_d;
  logic group_q, group_d;
  logic done_q, done_d;
  logic [5:0] hash_idx;
  logic [31:0] crc_next;

  always_comb begin
    crc_next = {crc_q[30:0], 1'b0};
    if (crc_q[31] ^ flt.bit_data) begin
      crc_next = crc_next ^ CRC_POLY;
    end
  end

  // top bits taken as the last address bit enters
  assign hash_idx = crc_next[HASH_MSB:HASH_LSB];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    da_d = da_q;
    crc_d = crc_q;
    accept_d = accept_q;
    group_d = group_q;
    done_d = 1'b0;
    if (flt.frame_start) begin
      state_d = ST_ADDR;
      cnt_d = 6'h00;
      crc_d = CRC_INIT;
      accept_d = 1'b0;
      group_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (flt.bit_valid) begin
            da_d[cnt_q] = flt.bit_data;
            crc_d = crc_next;
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == DA_LAST_BIT) begin
              state_d = ST_DONE;
              done_d = 1'b1;
              // first bit received marks a group address
              if (da_q[0]) begin
                // one-of-64 filter bit must be set
                accept_d = flt.group_enable & flt.hash_bits[hash_idx];
                group_d = accept_d;
              end else begin
                // whole station address compared in one 48-bit match
                accept_d = ({flt.bit_data, da_q[46:0]} == flt.station);
              end
            end
          end
        end
        ST_DONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= 6'h00;
      da_q <= 48'h000000000000;
      crc_q <= CRC_INIT;
      accept_q <= 1'b0;
      group_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      da_q <= da_d;
      crc_q <= crc_d;
      accept_q <= accept_d;
      group_q <= group_d;
      done_q <= done_d;
    end
  end

  // verdict stands one cycle after the last address bit
  assign flt.accept = accept_q;
  assign flt.is_group = group_q;
  assign flt.done = done_q;
endmodule : addr_filter

// ### logic/mac_dma_filter_tally_regs.sv
// MAC DMA pointers, receive address filter and error tallies behind an APB slave
// How it works
// - Whole programmed byte count is sent; no cut at 1500 bytes.
// - Ring built of 256-byte pages; first and last page hold address bits 15..8.
// - Next page equal to guard page aborts the local DMA.
// - Write page marks reception start; local pointer restored from it on error.
// - Local DMA address readable as two bytes, high byte bits 15..8.
// - Host transfer start split: low byte bits 7..0, high byte bits 15..8.
// - Host transfer advances address and cuts count by two per word, one per byte.
// - Host transfer count split into low byte and high byte 15..8.
// - Live host transfer address readable as two bytes, high byte bits 15..8.
// - Destination compared against six station bytes, byte0 holds bits 0..7.
// - First destination bit received is the group indicator.
// - Destination fed through CRC; top 6 bits taken as the last bit enters.
// - Hash index picks one filter bit; group frame accepted only if set.
// - Filter byte n holds bits 8n..8n+7; hash 32 is byte4 bit0.
// - Three 8-bit tallies that never exceed 192.
// - Reading a tally clears it.
// - Alignment tally counts recognised frames ending with alignment error.
// - CRC tally counts recognised frames with CRC error.
// - Lost tally counts frames dropped for no buffer; in check-only mode every recognised frame.
// - Check-only mode checks frames but never stores them.
// - With group accept enabled, group frames must pass the hash filter.
// - All registers are 8 bits; 16-bit values split into two bytes.
`timescale 1ns/1ns
module mac_dma_filter_tally_regs
  import mac_regs_pkg::*;
(
  input wire logic i_clk,                              // Bus clock, 250 MHz
  input wire logic i_nrst,                             // Async reset, active low
  input wire logic i_psel,                             // APB select
  input wire logic i_penable,                          // APB access phase
  input wire logic i_pwrite,                           // APB write
  input wire mac_regs_pkg::paddr_type i_paddr,         // APB byte address
  input wire mac_regs_pkg::word_type i_pwdata,         // APB write data
  output mac_regs_pkg::word_type o_prdata,             // APB read data
  output logic o_pready,                               // APB ready
  output logic o_pslverr,                              // APB error, unmapped address
  input wire logic i_check_only_receive,               // Check but do not store frames
  input wire logic i_group_accept_enable,              // Accept hashed group frames
  input wire logic i_rx_frame_start,                   // Pulse: sync seen, address follows
  input wire logic i_rx_bit_valid,                     // Pulse: one address bit present
  input wire logic i_rx_bit,                           // Serial address bit
  input wire logic i_rx_end,                           // Pulse: frame ended
  input wire logic i_rx_crc_err,                       // With end: CRC error
  input wire logic i_rx_align_err,                     // With end: alignment error
  input wire logic i_rx_no_buffer,                     // With end: dropped for no buffer
  output logic o_addr_done,                            // Pulse: verdict valid
  output logic o_addr_accept,                          // Frame address recognised
  output logic o_addr_is_group,                        // Recognised as group address
  output logic o_rx_store,                             // Frame may be stored to memory
  input wire logic i_ldma_rx_start,                    // Pulse: load pointer from write page
  input wire logic i_ldma_byte,                        // Pulse: one byte stored
  input wire logic i_rx_good,                          // Pulse: frame kept, advance write page
  input wire logic i_rx_error,                         // Pulse: receive error, rewind
  output mac_regs_pkg::addr16_type o_ldma_addr,        // Local DMA address
  output logic o_ldma_abort,                           // Pulse: ring full, DMA aborted
  input wire logic i_xfer_start,                       // Pulse: load host transfer
  input wire logic i_xfer_step,                        // Pulse: one transfer done
  input wire logic i_xfer_word,                        // Step is a word, else a byte
  output mac_regs_pkg::addr16_type o_xfer_addr,        // Host transfer address
  output logic o_xfer_count_zero,                      // Host transfer count at zero
  input wire logic i_tx_start,                         // Pulse: load transmit length
  input wire logic i_tx_byte,                          // Pulse: one byte sent
  output mac_regs_pkg::addr16_type o_tx_left,          // Transmit bytes still to send
  output logic o_tx_busy                               // Transmit bytes remain
);
  // ****************************************
  // Functions
  // ****************************************
  // pages wrap back to the first instead of entering the last page
  function automatic byte_type next_page(input byte_type page, input byte_type first,
                                         input byte_type last);
    byte_type nxt;
    nxt = page + 8'h01;
    if (nxt == last) begin
      nxt = first;
    end
    return nxt;
  endfunction : next_page

  // saturate at the ceiling, count onto the cleared value
  function automatic byte_type tally_next(input byte_type cnt, input logic clr,
                                          input logic inc);
    byte_type base;
    base = clr ? REG_RESET : cnt;
    if (inc && base < TALLY_MAX) begin
      base = base + 8'h01;
    end
    return base;
  endfunction : tally_next

  // ****************************************
  // Bus decode
  // ****************************************
  byte_type regs_q [NUM_REGS];
  byte_type regs_d [NUM_REGS];
  byte_type rdata_q, rdata_d;
  addr16_type ldma_q, ldma_d;
  addr16_type xfer_addr_q, xfer_addr_d;
  addr16_type xfer_cnt_q, xfer_cnt_d;
  addr16_type tx_left_q, tx_left_d;
  logic abort_q, abort_d;
  logic accept_seen_q, accept_seen_d;
  reg_idx_type idx;
  logic mapped;
  logic access;
  logic wr_en;
  logic rd_en;
  byte_type rd_mux;
  byte_type link_page;
  logic inc_align;
  logic inc_crc;
  logic inc_lost;
  addr16_type xfer_delta;

  assign idx = i_paddr[6:2];
  assign mapped = (i_paddr[7] == 1'b0) && (i_paddr[1:0] == 2'b00) && (idx <= LAST_REG);
  assign access = i_psel & i_penable;
  // Zero wait states: read data is captured in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = access & ~mapped;
  assign wr_en = access & i_pwrite & mapped;
  assign rd_en = access & ~i_pwrite & mapped;

  // 16-bit values appear as byte pairs
  always_comb begin
    rd_mux = REG_RESET;
    unique case (idx)
      LOCAL_DMA_ADDR_LOW: rd_mux = ldma_q[7:0];
      LOCAL_DMA_ADDR_HIGH: rd_mux = ldma_q[15:8];
      HOST_XFER_ADDR_LOW: rd_mux = xfer_addr_q[7:0];
      HOST_XFER_ADDR_HIGH: rd_mux = xfer_addr_q[15:8];
      default: rd_mux = mapped ? regs_q[idx] : REG_RESET;
    endcase
  end

  always_comb begin
    rdata_d = rdata_q;
    if (i_psel && !i_penable) begin
      rdata_d = rd_mux;
    end
  end

  assign o_prdata = {24'h000000, rdata_q};

  // ****************************************
  // Receive filter
  // ****************************************
  addr_filter_if flt_bus ();

  assign flt_bus.bit_valid = i_rx_bit_valid;
  assign flt_bus.bit_data = i_rx_bit;
  assign flt_bus.frame_start = i_rx_frame_start;
  assign flt_bus.group_enable = i_group_accept_enable;

  // byte0 holds the first eight address bits received
  always_comb begin
    for (int b = 0; b < STATION_BYTES; b++) begin
      flt_bus.station[8*b +: 8] = regs_q[int'(STATION_ADDR_BYTE0) + b];
    end
  end

  // byte n supplies filter bits 8n..8n+7
  always_comb begin
    for (int b = 0; b < HASH_BYTES; b++) begin
      flt_bus.hash_bits[8*b +: 8] = regs_q[int'(HASH_FILTER_BYTE0) + b];
    end
  end

  addr_filter u_filter (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .flt(flt_bus)
  );

  assign o_addr_done = flt_bus.done;
  assign o_addr_accept = flt_bus.accept;
  assign o_addr_is_group = flt_bus.is_group;
  assign o_rx_store = flt_bus.accept & ~i_check_only_receive;

  always_comb begin
    accept_seen_d = accept_seen_q;
    if (i_rx_frame_start) begin
      accept_seen_d = 1'b0;
    end else if (flt_bus.done) begin
      accept_seen_d = flt_bus.accept;
    end
  end

  assign inc_align = i_rx_end & accept_seen_q & i_rx_align_err;
  assign inc_crc = i_rx_end & accept_seen_q & i_rx_crc_err;
  // lost frames, or every recognised frame when only checking
  assign inc_lost = i_check_only_receive ? (i_rx_end & accept_seen_q)
                                         : ((i_rx_end & i_rx_no_buffer) | abort_q);

  // ****************************************
  // Registers and pointers
  // ****************************************
  assign link_page = next_page(ldma_q[15:8], regs_q[RING_FIRST_PAGE],
                               regs_q[RING_LAST_PAGE]);
  // step size follows the transfer width
  assign xfer_delta = i_xfer_word ? 16'h0002 : 16'h0001;

  always_comb begin
    regs_d = regs_q;
    ldma_d = ldma_q;
    xfer_addr_d = xfer_addr_q;
    xfer_cnt_d = xfer_cnt_q;
    tx_left_d = tx_left_q;
    abort_d = 1'b0;
    // host writes the write page; read-only and tally slots ignore writes
    if (wr_en && idx != LOCAL_DMA_ADDR_LOW && idx != LOCAL_DMA_ADDR_HIGH &&
        idx != HOST_XFER_ADDR_LOW && idx != HOST_XFER_ADDR_HIGH &&
        idx < ALIGNMENT_ERROR_TALLY) begin
      regs_d[idx] = i_pwdata[7:0];
    end
    // reception starts at the write page
    if (i_ldma_rx_start || i_rx_error) begin
      ldma_d = {regs_q[RX_WRITE_PAGE], PAGE_OFFSET_ZERO};
    end else if (i_ldma_byte) begin
      if (ldma_q[7:0] == 8'hff) begin
        // guard page reached: abort instead of linking
        if (link_page == regs_q[RING_GUARD_PAGE]) begin
          abort_d = 1'b1;
        end else begin
          ldma_d = {link_page, PAGE_OFFSET_ZERO};
        end
      end else begin
        ldma_d = ldma_q + 16'h0001;
      end
    end
    // Good frame: next reception starts on the page after the last one used
    if (i_rx_good) begin
      regs_d[RX_WRITE_PAGE] = link_page;
    end
    // start address and count assembled from byte pairs
    if (i_xfer_start) begin
      xfer_addr_d = {regs_q[HOST_XFER_START_HIGH], regs_q[HOST_XFER_START_LOW]};
      xfer_cnt_d = {regs_q[HOST_XFER_COUNT_HIGH], regs_q[HOST_XFER_COUNT_LOW]};
    end else if (i_xfer_step) begin
      // address up and count down by the same amount
      xfer_addr_d = xfer_addr_q + xfer_delta;
      xfer_cnt_d = (xfer_cnt_q > xfer_delta) ? xfer_cnt_q - xfer_delta : 16'h0000;
    end
    // the full 16-bit count is sent, no length cap
    if (i_tx_start) begin
      tx_left_d = {regs_q[TX_LENGTH_HIGH], regs_q[TX_LENGTH_LOW]};
    end else if (i_tx_byte && tx_left_q != 16'h0000) begin
      tx_left_d = tx_left_q - 16'h0001;
    end
    // read clears, a coinciding event still counts
    regs_d[ALIGNMENT_ERROR_TALLY] = tally_next(regs_q[ALIGNMENT_ERROR_TALLY],
                                               rd_en && idx == ALIGNMENT_ERROR_TALLY, inc_align);
    regs_d[CRC_ERROR_TALLY] = tally_next(regs_q[CRC_ERROR_TALLY],
                                         rd_en && idx == CRC_ERROR_TALLY, inc_crc);
    regs_d[LOST_FRAME_TALLY] = tally_next(regs_q[LOST_FRAME_TALLY],
                                          rd_en && idx == LOST_FRAME_TALLY, inc_lost);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int r = 0; r < NUM_REGS; r++) begin
        regs_q[r] <= REG_RESET;
      end
      rdata_q <= REG_RESET;
      ldma_q <= 16'h0000;
      xfer_addr_q <= 16'h0000;
      xfer_cnt_q <= 16'h0000;
      tx_left_q <= 16'h0000;
      abort_q <= 1'b0;
      accept_seen_q <= 1'b0;
    end else begin
      regs_q <= regs_d;
      rdata_q <= rdata_d;
      ldma_q <= ldma_d;
      xfer_addr_q <= xfer_addr_d;
      xfer_cnt_q <= xfer_cnt_d;
      tx_left_q <= tx_left_d;
      abort_q <= abort_d;
      accept_seen_q <= accept_seen_d;
    end
  end

  assign o_ldma_addr = ldma_q;
  assign o_ldma_abort = abort_q;
  assign o_xfer_addr = xfer_addr_q;
  assign o_xfer_count_zero = (xfer_cnt_q == 16'h0000);
  assign o_tx_left = tx_left_q;
  assign o_tx_busy = (tx_left_q != 16'h0000);
endmodule : mac_dma_filter_tally_regs

// ### tb/mac_regs_monitor.sv
// Concurrent port checks for the MAC pointer, filter and tally block
`timescale 1ns/1ns
module mac_regs_monitor (
  input wire logic i_clk, // clock
  input wire logic i_nrst, // reset
  input wire logic i_psel, // select
  input wire logic i_penable, // access
  input wire mac_regs_pkg::paddr_type i_paddr, // address
  input wire mac_regs_pkg::word_type o_prdata, // read data
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic i_check_only_receive, // mode
  input wire logic i_rx_frame_start, // start
  input wire logic i_rx_bit_valid, // bit
  input wire logic o_addr_done, // verdict
  input wire logic o_addr_accept, // accept
  input wire logic o_addr_is_group, // group
  input wire logic o_rx_store, // store
  input wire logic i_xfer_start, // load
  input wire logic i_xfer_step, // step
  input wire logic i_xfer_word, // word
  input wire mac_regs_pkg::addr16_type o_xfer_addr, // address
  input wire logic i_tx_start, // load
  input wire logic i_tx_byte, // byte
  input wire mac_regs_pkg::addr16_type o_tx_left, // left
  input wire logic o_tx_busy // busy
);
  import mac_regs_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ****
  // Checks
  // ****
  sequence s_tx_step;
    i_tx_byte && o_tx_busy && !i_tx_start;
  endsequence
  sequence s_xfer_step;
    i_xfer_step && !i_xfer_start;
  endsequence
  a_ready_high: assert property (o_pready) else $error("ready low");
  a_rdata_byte: assert property (o_prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_unmapped_err: assert property (i_psel && i_penable && i_paddr == 8'h7c |-> o_pslverr)
    else $error("no error on unmapped access");
  a_done_timing: assert property (o_addr_done |-> $past(i_rx_bit_valid))
    else $error("verdict without last bit");
  a_group_accept: assert property (o_addr_is_group |-> o_addr_accept)
    else $error("group flag without accept");
  a_store_gate: assert property (o_rx_store == (o_addr_accept && !i_check_only_receive))
    else $error("store gate wrong");
  a_tx_count: assert property (s_tx_step |=> o_tx_left == $past(o_tx_left) - 16'h0001)
    else $error("tx count not decremented");
  a_tx_busy: assert property (o_tx_busy == (o_tx_left != 16'h0000))
    else $error("tx busy wrong");
  a_xfer_advance: assert property (s_xfer_step |=>
    o_xfer_addr == $past(o_xfer_addr) + ($past(i_xfer_word) ? 16'h0002 : 16'h0001))
    else $error("transfer address step wrong");
  a_frame_clear: assert property (i_rx_frame_start |=> !o_addr_accept && !o_addr_is_group)
    else $error("verdict not cleared");
endmodule : mac_regs_monitor
bind mac_dma_filter_tally_regs mac_regs_monitor u_mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_check_only_receive(i_check_only_receive),
  .i_rx_frame_start(i_rx_frame_start), .i_rx_bit_valid(i_rx_bit_valid),
  .o_addr_done(o_addr_done), .o_addr_accept(o_addr_accept), .o_addr_is_group(o_addr_is_group),
  .o_rx_store(o_rx_store), .i_xfer_start(i_xfer_start), .i_xfer_step(i_xfer_step),
  .i_xfer_word(i_xfer_word), .o_xfer_addr(o_xfer_addr), .i_tx_start(i_tx_start),
  .i_tx_byte(i_tx_byte), .o_tx_left(o_tx_left), .o_tx_busy(o_tx_busy));

// ### tb/apb_host_model.sv
// Host processor model issuing APB transfers
`timescale 1ns/1ns
module apb_host_model (
  input wire logic i_clk, // clock
  output logic o_psel = 1'b0, // select
  output logic o_penable = 1'b0, // access
  output logic o_pwrite = 1'b0, // write
  output mac_regs_pkg::paddr_type o_paddr = 8'h00, // address
  output mac_regs_pkg::word_type o_pwdata = 32'h00000000, // write data
  input wire mac_regs_pkg::word_type i_prdata, // read data
  input wire logic i_pready, // ready
  input wire logic i_pslverr // error
);
  import mac_regs_pkg::*;
  task automatic xfer(input logic w, input paddr_type a, input byte_type d,
                      output word_type r, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= {24'h000000, d};
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    // Released lines flip so stale values never look valid
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~{24'h000000, d};
  endtask : xfer
endmodule : apb_host_model

// ### tb/mac_dma_filter_tally_regs_test.sv
// Self-checking bench for the MAC pointer, filter and tally block
`timescale 1ns/1ns
module mac_dma_filter_tally_regs_test;
  import mac_regs_pkg::*;
  typedef struct packed {reg_idx_type idx; byte_type wd; byte_type ex;} row_type;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [10:0] pls = 11'h000;
  logic [4:0] lvl = 5'h00;
  logic mon = 1'b0;
  logic grp = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, done, acc, isg, store, abort, xzero, busy, e;
  paddr_type paddr;
  word_type pwdata, prdata, r;
  addr16_type ldma, xaddr, txleft;
  int error_cnt = 0;
  int checks = 0;
  int n;
  logic [5:0] h;
  logic [47:0] sta = 48'h5634_1200_ab02;
  logic [47:0] gda = 48'h0000_5e00_0101;
  // write page equals first page; split low and high bytes
  row_type rows [11] = '{'{TX_LENGTH_LOW, 8'h01, 8'h01}, '{TX_LENGTH_HIGH, 8'h06, 8'h06},
    '{RING_FIRST_PAGE, 8'h40, 8'h40}, '{RING_LAST_PAGE, 8'h41, 8'h41},
    '{RING_GUARD_PAGE, 8'h40, 8'h40}, '{RX_WRITE_PAGE, 8'h40, 8'h40},
    '{HOST_XFER_START_LOW, 8'hfe, 8'hfe}, '{HOST_XFER_START_HIGH, 8'h12, 8'h12},
    '{HOST_XFER_COUNT_LOW, 8'h03, 8'h03}, '{LOCAL_DMA_ADDR_LOW, 8'h5a, 8'h00},
    '{HOST_XFER_ADDR_HIGH, 8'h77, 8'h00}};
  mac_dma_filter_tally_regs u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_check_only_receive(mon), .i_group_accept_enable(grp),
    .i_rx_frame_start(pls[0]), .i_rx_bit_valid(pls[1]), .i_rx_bit(lvl[0]), .i_rx_end(pls[2]),
    .i_rx_crc_err(lvl[1]), .i_rx_align_err(lvl[2]), .i_rx_no_buffer(lvl[3]),
    .o_addr_done(done), .o_addr_accept(acc), .o_addr_is_group(isg), .o_rx_store(store),
    .i_ldma_rx_start(pls[3]), .i_ldma_byte(pls[4]), .i_rx_good(pls[5]), .i_rx_error(pls[6]),
    .o_ldma_addr(ldma), .o_ldma_abort(abort), .i_xfer_start(pls[7]), .i_xfer_step(pls[8]),
    .i_xfer_word(lvl[4]), .o_xfer_addr(xaddr), .o_xfer_count_zero(xzero),
    .i_tx_start(pls[9]), .i_tx_byte(pls[10]), .o_tx_left(txleft), .o_tx_busy(busy));
  apb_host_model u_host (.i_clk(i_clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr));
  always #2 i_clk = ~i_clk;
  // ****
  // Helpers
  // ****
  task automatic chk(input word_type seen, input word_type exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input reg_idx_type i, input byte_type d);
    u_host.xfer(1'b1, {1'b0, i, 2'b00}, d, r, e);
  endtask : wr
  task automatic rd(input reg_idx_type i);
    u_host.xfer(1'b0, {1'b0, i, 2'b00}, 8'h00, r, e);
  endtask : rd
  task automatic ev(input int k, input logic [4:0] lv);
    @(posedge i_clk);
    pls <= 11'h001 << k;
    lvl <= lv;
    @(posedge i_clk);
    pls <= 11'h000;
  endtask : ev
  function automatic logic [5:0] hash6(input logic [47:0] da);
    logic [31:0] c = CRC_INIT;
    for (int i = 0; i < DA_BITS; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h0);
    return c[HASH_MSB:HASH_LSB];
  endfunction : hash6
  task automatic frame(input logic [47:0] da, input logic a, input logic g);
    ev(0, 5'h00);
    for (int i = 0; i < DA_BITS; i++) ev(1, {4'h0, da[i]});
    @(negedge i_clk);
    chk(done, 1'b1);
    chk(acc, a);
    chk(isg, g);
  endtask : frame
  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    final_report();
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(negedge i_clk);
    chk(xzero, 1'b1);
    rd(CRC_ERROR_TALLY);
    chk(r, {24'h000000, REG_RESET});
    foreach (rows[k]) begin
      wr(rows[k].idx, rows[k].wd);
      rd(rows[k].idx);
      chk(r, {24'h000000, rows[k].ex});
    end
    u_host.xfer(1'b0, 8'h7c, 8'h00, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    $display("end registers");
    for (int i = 0; i < STATION_BYTES; i++) wr(STATION_ADDR_BYTE0 + 5'(i), sta[8*i +: 8]);
    frame(sta, 1'b1, 1'b0);
    frame(sta ^ 48'h0100_0000_0000, 1'b0, 1'b0);
    h = hash6(gda);
    @(posedge i_clk);
    grp <= 1'b1;
    frame(gda, 1'b0, 1'b0);
    wr(HASH_FILTER_BYTE0 + 5'(h[5:3]), 8'h01 << h[2:0]);
    frame(gda, 1'b1, 1'b1);
    @(posedge i_clk);
    grp <= 1'b0;
    frame(gda, 1'b0, 1'b0);
    @(posedge i_clk);
    grp <= 1'b1;
    for (int i = 0; i < HASH_BYTES; i++) wr(HASH_FILTER_BYTE0 + 5'(i), 8'hff);
    frame(gda ^ 48'h1000_0000_0000, 1'b1, 1'b1);
    $display("end filter");
    ev(2, 5'h02);
    rd(CRC_ERROR_TALLY);
    chk(r, 32'h1);
    fork
      rd(CRC_ERROR_TALLY);
      @(posedge i_clk) ev(2, 5'h02);
    join
    chk(r, 32'h0);
    rd(CRC_ERROR_TALLY);
    chk(r, 32'h1);
    ev(2, 5'h04);
    rd(ALIGNMENT_ERROR_TALLY);
    chk(r, 32'h1);
    ev(2, 5'h08);
    rd(LOST_FRAME_TALLY);
    chk(r, 32'h1);
    repeat (200) ev(2, 5'h02);
    rd(CRC_ERROR_TALLY);
    chk(r, {24'h000000, TALLY_MAX});
    frame(sta ^ 48'h0000_0000_0100, 1'b0, 1'b0);
    ev(2, 5'h02);
    rd(CRC_ERROR_TALLY);
    chk(r, 32'h0);
    frame(sta, 1'b1, 1'b0);
    chk(store, 1'b1);
    @(posedge i_clk);
    mon <= 1'b1;
    @(negedge i_clk);
    chk(store, 1'b0);
    ev(2, 5'h00);
    rd(LOST_FRAME_TALLY);
    chk(r, 32'h1);
    $display("end tallies");
    ev(7, 5'h00);
    @(negedge i_clk);
    chk(xaddr, 16'h12fe);
    ev(8, 5'h10);
    @(negedge i_clk);
    chk(xaddr, 16'h1300);
    rd(HOST_XFER_ADDR_HIGH);
    chk(r, 32'h13);
    ev(8, 5'h00);
    @(negedge i_clk);
    chk(xzero, 1'b1);
    ev(9, 5'h00);
    @(negedge i_clk);
    chk(txleft, 16'h0601);
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      ev(10, 5'h00);
      n++;
      @(negedge i_clk);
    end
    chk(n, 32'd1537);
    ev(3, 5'h00);
    @(negedge i_clk);
    chk(ldma, 16'h4000);
    repeat (256) ev(4, 5'h00);
    @(negedge i_clk);
    chk(abort, 1'b1);
    chk(ldma, 16'h40ff);
    rd(LOCAL_DMA_ADDR_HIGH);
    chk(r, 32'h40);
    ev(6, 5'h00);
    @(negedge i_clk);
    chk(ldma, 16'h4000);
    $display("end pointers");
    final_report();
  end
endmodule : mac_dma_filter_tally_regs_test
